// ===== sio3_sync.sv
/*
 * Constants package of the three-wire serial port, plus the three-stage
 * input synchroniser used for the select pin and the done toggle entering the system clock domain.
 * Assumes a single system clock clk_in with a synchronous active-high reset.
 */

package sio3_pkg;

  // Transfer framing
  localparam int unsigned SIO3_XFER_BITS = 8;
  localparam logic [2:0] SIO3_LAST_CNT = 3'h7;
  localparam logic [2:0] SIO3_FIRST_CNT = 3'h0;
  localparam logic [2:0] SIO3_MSB_POS = 3'h7;
  localparam logic [2:0] SIO3_LSB_POS = 3'h0;

  // Clock select code that hands the serial clock to the far master
  localparam logic [2:0] SIO3_CLK_SEL_SLAVE = 3'h7;

  // Master clock generator: edges per byte, half period for code 0
  localparam logic [4:0] SIO3_MASTER_EDGES = 5'h10;
  localparam logic [6:0] SIO3_HALF_BASE = 7'h01;

  // Values after reset
  localparam logic [7:0] SIO3_BYTE_RST = 8'h00;
  localparam logic [6:0] SIO3_DIV_RST = 7'h00;
  localparam logic [4:0] SIO3_EDGE_RST = 5'h00;
  localparam logic SIO3_BIT_RST = 1'b0;

  typedef enum logic [1:0] {
    SIO3_IDLE = 2'b00,
    SIO3_HOLD = 2'b01,
    SIO3_RUN = 2'b11,
    SIO3_FIN = 2'b10
  } sio3_state_t;

endpackage

`timescale 1ns/100ps
`default_nettype none

module sio3_sync
  import sio3_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic async_in,
  output logic stable_out
);

  logic meta;
  logic stage2;
  logic stage3;
  wire agree = (stage2 == stage3);

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      meta <= SIO3_BIT_RST;
      stage2 <= SIO3_BIT_RST;
      stage3 <= SIO3_BIT_RST;
      stable_out <= SIO3_BIT_RST;
    end else begin
      meta <= async_in;
      stage2 <= meta;
      stage3 <= stage2;
      // A change counts only once two settled stages agree
      if (agree) begin
        stable_out <= stage3;
      end
    end
  end

endmodule

`default_nettype wire

// ===== sio3_serial_io.sv
/*
 * Three-wire clocked serial port engine: transmit buffer, shift register,
 * busy and completion flags, optional active-low slave select.
 * Assumes the serial clock pin is looped back through the pad to
 * serial_clock_pin_in, so the shift logic always runs on the pin level; in
 * master mode the block drives that pin from a divider of clk_in.
 * Configuration inputs stay still while a transfer is busy.
 */

`timescale 1ns/100ps
`default_nettype none

module sio3_serial_io
  import sio3_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic port_enable_in,
  input wire logic xfer_direction_sel_in,
  input wire logic slave_select_enable_in,
  input wire logic data_phase_sel_in,
  input wire logic bit_order_sel_in,
  input wire logic clock_polarity_sel_in,
  input wire logic clk_select_b2_in,
  input wire logic clk_select_b1_in,
  input wire logic clk_select_b0_in,
  input wire logic tx_wr_in,
  input wire logic [7:0] tx_wdata_in,
  input wire logic shift_rd_in,
  input wire logic irq_flag_clr_in,
  input wire logic slave_select_in_n_in,
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe_n_out,
  input wire logic serial_data_in_in,
  output logic serial_data_out_out,
  output logic [7:0] tx_buffer_out,
  output logic [7:0] serial_shift_reg_out,
  output logic xfer_busy_flag_out,
  output logic xfer_done_irq_flag_out,
  output logic xfer_done_irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Shared decoding

  // Bit that leaves first, or the bit that follows in the shift register
  function automatic logic lead_bit(input logic [7:0] value, input logic lsb_first);
    if (lsb_first) begin
      lead_bit = value[SIO3_LSB_POS];
    end else begin
      lead_bit = value[SIO3_MSB_POS];
    end
  endfunction

  // One shift step, receive bit entering the end opposite the sent one
  function automatic logic [7:0] shift_step(input logic [7:0] value, input logic lsb_first,
                                            input logic rx_bit);
    if (lsb_first) begin
      shift_step = {rx_bit, value[7:1]};
    end else begin
      shift_step = {value[6:0], rx_bit};
    end
  endfunction

  wire [2:0] clk_select = {clk_select_b2_in, clk_select_b1_in, clk_select_b0_in};
  wire slave_mode = (clk_select == SIO3_CLK_SEL_SLAVE);
  wire select_used = slave_mode && slave_select_enable_in;

  ////////////////////////////////////////////////////////////////////////////
  // System domain state

  sio3_state_t state;
  sio3_state_t next_state;
  logic [7:0] tx_buffer;
  logic [7:0] serial_shift_reg;
  logic done_flag;
  logic done_pulse;
  logic done_seen;
  logic link_rst;
  logic ever_started;
  logic [6:0] div_cnt;
  logic [4:0] edge_cnt;
  logic clk_phase;
  logic select_high_sync;
  logic done_tgl_sync;

  // Link domain state
  logic [2:0] bit_cnt;
  logic [7:0] link_shift;
  logic done_tgl;
  logic out_latch;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers into clk_in

  // Select pin and done toggle enter clk_in the same way
  logic [1:0] cross_raw;
  logic [1:0] cross_sync;

  assign cross_raw = {done_tgl, slave_select_in_n_in};
  assign select_high_sync = cross_sync[0];
  assign done_tgl_sync = cross_sync[1];

  // Only single bits cross here; the bytes stay still while they are read
  for (genvar g = 0; g < 2; g++) begin : g_cross
    sio3_sync u_sync (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .async_in(cross_raw[g]),
      .stable_out(cross_sync[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start triggers and transfer control

  wire busy = (state == SIO3_RUN);
  wire accept_access = (state != SIO3_RUN) && (state != SIO3_FIN);
  wire trig_write = tx_wr_in && xfer_direction_sel_in;
  wire trig_read = shift_rd_in && !xfer_direction_sel_in;
  wire start_trig = port_enable_in && (state == SIO3_IDLE) && (trig_write || trig_read);
  wire select_holds = select_used && select_high_sync;
  wire done_evt = (done_tgl_sync != done_seen);
  // Byte finished while running; drives flag, pulse and the shift copy
  wire done_hit = busy && done_evt;

  always_comb begin
    next_state = state;
    unique case (state)
      SIO3_IDLE: begin
        if (start_trig) begin
          // Held start waits for select to drop
          next_state = select_holds ? SIO3_HOLD : SIO3_RUN;
        end
      end
      SIO3_HOLD: begin
        if (!select_holds) begin
          next_state = SIO3_RUN;
        end
      end
      SIO3_RUN: begin
        if (done_evt) begin
          next_state = SIO3_FIN;
        end
      end
      SIO3_FIN: begin
        next_state = SIO3_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state <= SIO3_IDLE;
      done_seen <= SIO3_BIT_RST;
      link_rst <= 1'b1;
      ever_started <= SIO3_BIT_RST;
    end else begin
      state <= next_state;
      done_seen <= done_tgl_sync;
      link_rst <= 1'b0;
      if (next_state == SIO3_RUN) begin
        ever_started <= 1'b1;
      end
    end
  end

  // Writes while busy are dropped so the link never sees the buffer move
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      tx_buffer <= SIO3_BYTE_RST;
    end else if (tx_wr_in && accept_access) begin
      tx_buffer <= tx_wdata_in;
    end
  end

  // Link shift register is still once the done toggle has crossed
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      serial_shift_reg <= SIO3_BYTE_RST;
    end else if (done_hit) begin
      serial_shift_reg <= link_shift;
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      done_flag <= SIO3_BIT_RST;
      done_pulse <= SIO3_BIT_RST;
    end else begin
      done_pulse <= done_hit;
      if (done_hit) begin
        done_flag <= 1'b1;
      end else if (irq_flag_clr_in) begin
        done_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master serial clock generator

  // Code 7 never reaches the divider, so 64 cycles is the longest half period
  wire [6:0] half_period = SIO3_HALF_BASE << clk_select;
  wire [6:0] next_div = div_cnt + 7'h01;
  wire gen_run = busy && !slave_mode && (edge_cnt != SIO3_MASTER_EDGES);
  wire half_done = (next_div == half_period);

  always_ff @(posedge clk_in) begin
    if (sys_rst_in || !busy) begin
      div_cnt <= SIO3_DIV_RST;
      edge_cnt <= SIO3_EDGE_RST;
      clk_phase <= SIO3_BIT_RST;
    end else if (gen_run) begin
      if (half_done) begin
        div_cnt <= SIO3_DIV_RST;
        edge_cnt <= edge_cnt + 5'h01;
        clk_phase <= !clk_phase;
      end else begin
        div_cnt <= next_div;
      end
    end
  end

  // Idle level is high at polarity 0, so the leading edge falls
  always_comb begin
    serial_clock_pin_out = !clock_polarity_sel_in ^ clk_phase;
    serial_clock_pin_oe_n_out = !(port_enable_in && !slave_mode);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: shifting on the serial clock pin

  // Sample edge rises in the derived clock; drive edge falls
  wire lead_clk = serial_clock_pin_in ^ clock_polarity_sel_in;
  wire sample_clk = lead_clk ^ data_phase_sel_in;
  // Select is quasi-static around clocking, so it gates the link directly
  wire select_ok = !(select_used && slave_select_in_n_in);
  wire link_go = busy && select_ok;
  wire [7:0] shift_src = (bit_cnt == SIO3_FIRST_CNT) ? tx_buffer : link_shift;

  // Reset comes from a clk_in flop since the serial clock may stand still
  always_ff @(posedge sample_clk or posedge link_rst) begin
    if (link_rst) begin
      bit_cnt <= SIO3_FIRST_CNT;
      link_shift <= SIO3_BYTE_RST;
      done_tgl <= SIO3_BIT_RST;
    end else if (link_go) begin
      // First sample loads the buffer and shifts it once
      link_shift <= shift_step(shift_src, bit_order_sel_in, serial_data_in_in);
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == SIO3_LAST_CNT) begin
        done_tgl <= !done_tgl;
      end
    end
  end

  always_ff @(negedge sample_clk or posedge link_rst) begin
    if (link_rst) begin
      out_latch <= SIO3_BIT_RST;
    end else if (link_go) begin
      if ((bit_cnt == SIO3_FIRST_CNT) && !data_phase_sel_in) begin
        out_latch <= lead_bit(tx_buffer, bit_order_sel_in);
      end else if (bit_cnt != SIO3_FIRST_CNT) begin
        // Phase 0 drives on leading, phase 1 on trailing edges
        out_latch <= lead_bit(link_shift, bit_order_sel_in);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial data output selector

  // Phase 1 shows the first bit as soon as the transfer is launched
  wire show_first = busy && data_phase_sel_in && (bit_cnt == SIO3_FIRST_CNT) &&
                    (done_tgl == done_seen);
  // Output latch holds the last bit once the byte is done
  wire buffer_first = lead_bit(tx_buffer, bit_order_sel_in);
  wire tx_data = show_first ? buffer_first :
                 (ever_started ? out_latch : 1'b0);
  wire idle_level = data_phase_sel_in ? buffer_first : 1'b0;
  // Output table keyed on enable and direction
  wire [1:0] out_mode = {port_enable_in, xfer_direction_sel_in};

  always_comb begin
    // Pure selection, so any setting change reaches the pin at once
    unique case (out_mode)
      2'h3: begin
        serial_data_out_out = tx_data;
      end
      2'h1: begin
        serial_data_out_out = idle_level;
      end
      2'h2: begin
        serial_data_out_out = 1'b0;
      end
      2'h0: begin
        serial_data_out_out = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status outputs

  always_comb begin
    tx_buffer_out = tx_buffer;
    serial_shift_reg_out = serial_shift_reg;
    xfer_busy_flag_out = busy;
    xfer_done_irq_flag_out = done_flag;
    xfer_done_irq_out = done_pulse;
  end

endmodule

`default_nettype wire

// ===== sio3_serial_io_properties.sv
/* Concurrent checks on the ports of sio3_serial_io.
   Assumes one clk_in domain with sys_rst_in as its reset. */
`timescale 1ns/100ps
`default_nettype none
module sio3_serial_io_chk (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic port_enable_in,
  input wire logic xfer_direction_sel_in,
  input wire logic slave_select_enable_in,
  input wire logic data_phase_sel_in,
  input wire logic bit_order_sel_in,
  input wire logic clk_select_b2_in,
  input wire logic clk_select_b1_in,
  input wire logic clk_select_b0_in,
  input wire logic tx_wr_in,
  input wire logic shift_rd_in,
  input wire logic irq_flag_clr_in,
  input wire logic slave_select_in_n_in,
  input wire logic serial_clock_pin_oe_n_out,
  input wire logic serial_data_out_out,
  input wire logic [7:0] tx_buffer_out,
  input wire logic xfer_busy_flag_out,
  input wire logic xfer_done_irq_flag_out,
  input wire logic xfer_done_irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  wire slave = clk_select_b2_in & clk_select_b1_in & clk_select_b0_in;
  wire idle = port_enable_in & ~xfer_busy_flag_out & ~slave & ~xfer_done_irq_out;
  wire off_tx = ~port_enable_in & xfer_direction_sel_in;
  //////////////////////////////////////////////////////////////
  so_low_a: assert property (off_tx && !data_phase_sel_in |-> !serial_data_out_out)
    else $error("data out not low");
  so_table_a: assert property (off_tx && data_phase_sel_in |->
    serial_data_out_out == tx_buffer_out[bit_order_sel_in ? 0 : 7]) else $error("first bit wrong");
  rx_only_a: assert property (!xfer_direction_sel_in |-> !serial_data_out_out)
    else $error("receive only drives data");
  wr_start_a: assert property (idle && tx_wr_in && xfer_direction_sel_in |=> xfer_busy_flag_out)
    else $error("write did not start");
  rd_start_a: assert property (idle && shift_rd_in && !xfer_direction_sel_in |=> xfer_busy_flag_out)
    else $error("read did not start");
  hold_off_a: assert property ((slave && slave_select_enable_in && slave_select_in_n_in
    && !xfer_busy_flag_out) [*5] |=> !xfer_busy_flag_out) else $error("started while deselected");
  byte_len_a: assert property ($rose(xfer_busy_flag_out) && !slave |=> xfer_busy_flag_out [*8])
    else $error("transfer too short");
  done_pulse_a: assert property (xfer_done_irq_out |=> !xfer_done_irq_out)
    else $error("done pulse too long");
  done_idle_a: assert property (xfer_done_irq_out |-> xfer_done_irq_flag_out ##[0:2] !xfer_busy_flag_out)
    else $error("busy kept after done");
  flag_clr_a: assert property (irq_flag_clr_in |=> xfer_done_irq_flag_out == xfer_done_irq_out)
    else $error("flag clear wrong");
  clk_oe_a: assert property (slave || !port_enable_in |-> serial_clock_pin_oe_n_out)
    else $error("clock pin driven");
  cover property ($rose(xfer_done_irq_flag_out));
  cover property (slave && xfer_busy_flag_out);
  cover property (off_tx && data_phase_sel_in);
endmodule
bind sio3_serial_io sio3_serial_io_chk chk (.*);
`default_nettype wire

// ===== sio3_peer.sv
/* Behavioural far-side peer: clocks as master when go_in rises,
   otherwise shifts on the pin clock as a slave. */
`timescale 1ns/100ps
`default_nettype none
module sio3_peer (
  input wire logic sclk_in,
  input wire logic so_in,
  input wire logic [7:0] byte_in,
  input wire logic load_in,
  input wire logic go_in,
  input wire logic pause_in,
  output logic sclk_out,
  output logic ss_n_out,
  output logic miso_out,
  output logic [7:0] rx_out
);
  logic [7:0] tx = 8'h00;
  initial begin
    sclk_out = 1'b1;
    ss_n_out = 1'b1;
    miso_out = 1'b0;
    rx_out = 8'h00;
  end
  task automatic tick;
    sclk_out = 1'b0;
    #16;
    sclk_out = 1'b1;
    #16;
  endtask
  always @(posedge load_in) begin
    tx = byte_in;
    miso_out = tx[7];
  end
  // Deselected edges ignored while go_in is high; filler bits keep the idle line moving
  always @(posedge sclk_in) begin
    if (!(ss_n_out && go_in)) begin
      rx_out = {rx_out[6:0], so_in};
      #2;
      tx = {tx[6:0], ~tx[0]};
      miso_out = tx[7];
    end
  end
  always @(posedge go_in) begin
    #7;
    ss_n_out = 1'b0;
    #300;
    for (int i = 0; i < 8; i++) begin
      if (i == 4 && pause_in) begin
        ss_n_out = 1'b1;
        #64;
        repeat (2) tick();
        #64;
        ss_n_out = 1'b0;
        #300;
      end
      tick();
    end
    #32;
    ss_n_out = 1'b1;
  end
endmodule
`default_nettype wire

// ===== tb_top.sv
/* Self-checking bench for sio3_serial_io with the sio3_peer model.
   Assumes the checker is bound from its own file. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk_in = 1'b0, sys_rst_in = 1'b1, port_enable_in = 1'b0, tx_wr_in = 1'b0;
  logic xfer_direction_sel_in = 1'b1, slave_select_enable_in = 1'b0, shift_rd_in = 1'b0;
  logic data_phase_sel_in = 1'b0, bit_order_sel_in = 1'b0, clock_polarity_sel_in = 1'b0;
  logic clk_select_b2_in = 1'b0, clk_select_b1_in = 1'b0, clk_select_b0_in = 1'b0;
  logic irq_flag_clr_in = 1'b0, p_load = 1'b0, p_go = 1'b0, p_pause = 1'b0;
  logic [7:0] tx_wdata_in = 8'h00, p_byte = 8'h00, p_rx, tx_buffer_out, serial_shift_reg_out;
  logic serial_clock_pin_out, serial_clock_pin_oe_n_out, serial_data_out_out, p_sclk;
  logic xfer_busy_flag_out, xfer_done_irq_flag_out, xfer_done_irq_out;
  wire logic slave_select_in_n_in, serial_data_in_in, serial_clock_pin_in;
  logic [3:0] tbl [5] = '{4'h4, 4'h6, 4'h7, 4'h3, 4'hb};
  int num_errors = 0, check_count = 0;
  // Pad loopback: the block's own clock wins whenever it drives the pin
  assign serial_clock_pin_in = serial_clock_pin_oe_n_out ? p_sclk : serial_clock_pin_out;
  sio3_serial_io uut (.*);
  sio3_peer peer (.sclk_in(serial_clock_pin_in), .so_in(serial_data_out_out),
    .byte_in(p_byte), .load_in(p_load), .go_in(p_go), .pause_in(p_pause), .sclk_out(p_sclk),
    .ss_n_out(slave_select_in_n_in), .miso_out(serial_data_in_in), .rx_out(p_rx));
  //////////////////////////////////////////////////////////////
  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk_in) s = 1'b1;
    @(negedge clk_in) s = 1'b0;
  endtask
  task automatic wait_done;
    int n = 0;
    while (xfer_done_irq_flag_out !== 1'b1 && n < 500) begin
      @(negedge clk_in);
      n++;
    end
    @(negedge clk_in);
    chk(xfer_done_irq_flag_out === 1'b1, "no completion");
  endtask
  task automatic wrap_up;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////
  task automatic t_table;
    chk(serial_data_out_out === 1'b0 && xfer_busy_flag_out === 1'b0, "reset state");
    tx_wdata_in = 8'h80;
    pulse(tx_wr_in);
    chk(tx_buffer_out === 8'h80 && xfer_busy_flag_out === 1'b0, "disabled write");
    for (int i = 0; i < 5; i++) begin
      @(negedge clk_in);
      {port_enable_in, xfer_direction_sel_in, data_phase_sel_in, bit_order_sel_in} = tbl[i];
      #1;
      chk(serial_data_out_out === (i == 1), "output table");
    end
  endtask
  task automatic t_slave;
    {clk_select_b2_in, clk_select_b1_in, clk_select_b0_in} = 3'h7;
    {port_enable_in, xfer_direction_sel_in, data_phase_sel_in, bit_order_sel_in} = 4'hc;
    slave_select_enable_in = 1'b1;
    p_byte = 8'ha6;
    p_pause = 1'b1;
    pulse(p_load);
    tx_wdata_in = 8'h5b;
    pulse(tx_wr_in);
    repeat (10) @(negedge clk_in);
    chk(xfer_busy_flag_out === 1'b0, "started while deselected");
    p_go = 1'b1;
    repeat (12) @(negedge clk_in);
    chk(xfer_busy_flag_out === 1'b1, "held start lost");
    wait_done();
    chk(serial_shift_reg_out === 8'ha6 && p_rx === 8'h5b, "slave bytes");
    p_go = 1'b0;
    pulse(irq_flag_clr_in);
    chk(xfer_done_irq_flag_out === 1'b0, "flag kept");
    chk(serial_data_out_out === 1'b1 && xfer_busy_flag_out === 1'b0, "last bit lost");
  endtask
  task automatic t_master;
    {clk_select_b2_in, clk_select_b1_in, clk_select_b0_in} = 3'h1;
    {port_enable_in, xfer_direction_sel_in, data_phase_sel_in, bit_order_sel_in} = 4'hb;
    p_byte = 8'h1d;
    pulse(p_load);
    pulse(shift_rd_in);
    wait_done();
    chk(serial_shift_reg_out === 8'hb8, "lsb first receive");
    chk(serial_data_out_out === 1'b0 && serial_clock_pin_oe_n_out === 1'b0, "master pins");
    pulse(irq_flag_clr_in);
    xfer_direction_sel_in = 1'b1;
    tx_wdata_in = 8'h80;
    pulse(tx_wr_in);
    wait_done();
    chk(serial_data_out_out === 1'b1, "last bit lost");
  endtask
  //////////////////////////////////////////////////////////////
  initial forever #25 clk_in = ~clk_in;
  initial begin
    #400000;
    num_errors++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    wrap_up();
  end
  initial begin
    repeat (12) @(negedge clk_in);
    sys_rst_in = 1'b0;
    repeat (4) @(negedge clk_in);
    t_table();
    t_slave();
    t_master();
    wrap_up();
  end
endmodule
`default_nettype wire
